// ==== uptd_core.v ====
// Termination decode, receive path and transmit path of the hi-speed transceiver logic.
//
// The plain strobed port and the address map were decided locally.
`include "uptd_defines.vh"

module uptd_core
(
	input  wire       clk,
	input  wire       sys_rst,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	input  wire       hs_rx_bit,
	input  wire       fs_rx_bit,
	input  wire       hs_squelch,
	input  wire       se_dplus,
	input  wire       se_dminus,
	output reg        rx_bit,
	output reg        rx_bit_valid,
	output reg  [1:0] line_state,
	input  wire [7:0] tx_data,
	input  wire       tx_valid,
	output reg        tx_ready,
	output reg        tx_line,
	output reg        hs_tx_drive,
	output reg        fs_tx_drive,
	output reg  [2:0] hs_tx_amplitude,
	output reg        dplus_pullup_on,
	output reg        dminus_pullup_on,
	output reg        dplus_pulldown_on,
	output reg        dminus_pulldown_on,
	output reg        fast_termination_on
);

	localparam TX_IDLE  = 3'b001;
	localparam TX_SHIFT = 3'b010;
	localparam TX_STUFF = 3'b100;

	reg  [7:0] func_ctrl_reg;
	reg  [7:0] otg_ctrl_reg;
	reg  [7:0] boost_reg;
	reg  [2:0] tx_state_reg;
	reg  [2:0] tx_state_next;
	reg  [7:0] tx_shift_reg;
	reg  [7:0] tx_shift_next;
	reg  [2:0] tx_count_reg;
	reg  [2:0] tx_count_next;
	reg  [2:0] tx_ones_reg;
	reg  [2:0] tx_ones_next;
	reg        tx_last_reg;
	reg        tx_last_next;
	reg        tx_line_next;
	reg        tx_take;
	reg  [4:0] term_next;
	reg  [7:0] rd_mux;

	wire [1:0] transceiver_speed_select;
	wire       termination_select;
	wire [1:0] line_operation_select;
	wire       dplus_pulldown_request;
	wire       dminus_pulldown_request;
	wire       hs_mode;
	wire       op_legal;

	assign transceiver_speed_select = func_ctrl_reg[`UPTD_FC_XCVR_MSB:`UPTD_FC_XCVR_LSB];
	assign termination_select       = func_ctrl_reg[`UPTD_FC_TERM_BIT];
	assign line_operation_select    = func_ctrl_reg[`UPTD_FC_LINE_OPERATION_SELECT_MSB:`UPTD_FC_LINE_OPERATION_SELECT_LSB];
	assign dplus_pulldown_request   = otg_ctrl_reg[`UPTD_OTG_DP_PD_BIT];
	assign dminus_pulldown_request  = otg_ctrl_reg[`UPTD_OTG_DM_PD_BIT];
	assign hs_mode                  = (transceiver_speed_select == `UPTD_XCVR_HS);
	// Line operation 11 belongs to no row, so it must never reach a termination.
	assign op_legal                 = (line_operation_select == `UPTD_OP_NORMAL) ||
		(line_operation_select == `UPTD_OP_NOSTUFF);

	// Register file; control-register reserved bits are kept so software reads back what it wrote, but the boost register keeps only bits 2:0.
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			func_ctrl_reg <= `UPTD_FC_RESET;
			otg_ctrl_reg  <= `UPTD_OTG_RESET;
			boost_reg     <= `UPTD_BOOST_RESET;
		end
		else if (reg_wr)
		begin
			// Writes to unmapped offsets fall through every compare and change nothing.
			if (reg_addr == `UPTD_ADDR_FUNC_CTRL)
				func_ctrl_reg <= reg_wdata;
			if (reg_addr == `UPTD_ADDR_OTG_CTRL)
				otg_ctrl_reg <= reg_wdata;
			if (reg_addr == `UPTD_ADDR_TX_BOOST)
				boost_reg <= {5'h00, reg_wdata[`UPTD_BOOST_MSB:0]};
		end
	end

	// Status gathers the line state and the live enables for software.
	always @*
	begin
		case (reg_addr)
			`UPTD_ADDR_FUNC_CTRL: rd_mux = func_ctrl_reg;
			`UPTD_ADDR_OTG_CTRL:  rd_mux = otg_ctrl_reg;
			`UPTD_ADDR_TX_BOOST:  rd_mux = boost_reg;
			`UPTD_ADDR_STATUS:    rd_mux = {1'b0, line_state, dplus_pullup_on, dminus_pullup_on,
				dplus_pulldown_on, dminus_pulldown_on, fast_termination_on};
			default:              rd_mux = 8'h00;
		endcase
	end

	// Read data stands for one cycle and is zero otherwise, so no stale value lingers.
	always @(posedge clk)
	begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= 8'h00;
	end

	// Decode order {dp pull-up, dm pull-up, dp pull-down, dm pull-down, hs termination}.
	// Suspend and normal rows share codes, so one term covers both.
	// Accepted rows, written as transceiver select, termination select, line operation:
	// Both requests, 01 0 00: both pull-downs, the power-up default.
	// Both requests, 00 0 00 or 10: both pull-downs and the hi-speed termination.
	// Both requests, 01 or 10 with 1 and 00 or 10, or 11 1 00: both pull-downs.
	// No request, 00 1 10, or 01 1 00 or 10: the DP pull-up.
	// No request, 00 0 00 or 10: the hi-speed termination.
	// No request, 10 1 00 or 10: the DM pull-up.
	// DM request alone: the DP pull-up or termination rows plus the DM pull-down.
	// Everything else, line operation 11 and a DP request alone included, is all off,
	// so that an unlisted write can never leave a stray resistor switched in.
	always @*
	begin
		term_next = 5'h00;
		if (line_operation_select == `UPTD_OP_NONDRIVE)
			term_next = 5'h00;
		else if (!op_legal)
			term_next = 5'h00;
		else if (dplus_pulldown_request && dminus_pulldown_request)
		begin
			if (!termination_select && transceiver_speed_select == `UPTD_XCVR_FS &&
				line_operation_select == `UPTD_OP_NORMAL)
				term_next = 5'h06;
			else if (!termination_select && hs_mode)
				term_next = 5'h07;
			else if (termination_select && (transceiver_speed_select == `UPTD_XCVR_FS ||
				transceiver_speed_select == `UPTD_XCVR_LS))
				term_next = 5'h06;
			else if (termination_select && transceiver_speed_select == `UPTD_XCVR_FS4LS &&
				line_operation_select == `UPTD_OP_NORMAL)
				term_next = 5'h06;
			else
				term_next = 5'h00;
		end
		else if (!dplus_pulldown_request)
		begin
			if (termination_select && hs_mode &&
				line_operation_select == `UPTD_OP_NOSTUFF)
				term_next = 5'h10;
			else if (termination_select && transceiver_speed_select == `UPTD_XCVR_FS)
				term_next = 5'h10;
			else if (!termination_select && hs_mode)
				term_next = 5'h01;
			else if (termination_select && !dminus_pulldown_request &&
				transceiver_speed_select == `UPTD_XCVR_LS)
				term_next = 5'h08;
			else
				term_next = 5'h00;
			if (dminus_pulldown_request && term_next != 5'h00)
				term_next = term_next | 5'h02;
		end
		else
			term_next = 5'h00;
	end

	// One flop stage after the decode, so enables move one clock after the write.
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			dplus_pullup_on     <= 1'b0;
			dminus_pullup_on    <= 1'b0;
			dplus_pulldown_on   <= 1'b0;
			dminus_pulldown_on  <= 1'b0;
			fast_termination_on <= 1'b0;
		end
		else
		begin
			dplus_pullup_on     <= term_next[4];
			dminus_pullup_on    <= term_next[3];
			dplus_pulldown_on   <= term_next[2];
			dminus_pulldown_on  <= term_next[1];
			fast_termination_on <= term_next[0];
		end
	end

	// Receive path.
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			rx_bit       <= 1'b0;
			rx_bit_valid <= 1'b0;
			line_state   <= 2'h0;
		end
		else
		begin
			// A squelched hi-speed sample reads as zero, so noise never passes as data.
			// The full/low-speed receiver has no squelch, so every sample is valid.
			if (hs_mode)
			begin
				rx_bit       <= hs_squelch ? 1'b0 : hs_rx_bit;
				rx_bit_valid <= !hs_squelch;
			end
			else
			begin
				rx_bit       <= fs_rx_bit;
				rx_bit_valid <= 1'b1;
			end
			line_state <= {se_dminus, se_dplus};
		end
	end

	// Transmit path: byte in, LSB first, a zero stuffed after six ones, NRZI.
	// Stuffing is skipped in the no-stuff line operation used for chirp and test patterns.
	always @*
	begin
		tx_state_next = tx_state_reg;
		tx_shift_next = tx_shift_reg;
		tx_count_next = tx_count_reg;
		tx_ones_next  = tx_ones_reg;
		tx_last_next  = tx_last_reg;
		tx_line_next  = tx_line;
		tx_take       = 1'b0;
		case (tx_state_reg)
			TX_IDLE:
			begin
				tx_line_next = 1'b1;
				tx_ones_next = 3'h0;
				if (tx_valid && line_operation_select != `UPTD_OP_NONDRIVE)
				begin
					tx_take       = 1'b1;
					tx_shift_next = tx_data;
					tx_count_next = 3'h0;
					tx_state_next = TX_SHIFT;
				end
			end
			TX_SHIFT:
			begin
				tx_line_next  = tx_shift_reg[0] ? tx_line : !tx_line;
				tx_ones_next  = tx_shift_reg[0] ? tx_ones_reg + 3'h1 : 3'h0;
				tx_shift_next = {1'b0, tx_shift_reg[7:1]};
				tx_count_next = tx_count_reg + 3'h1;
				tx_last_next  = (tx_count_reg == 3'h7);
				if (tx_shift_reg[0] && tx_ones_reg == `UPTD_STUFF_RUN - 3'h1 &&
					line_operation_select != `UPTD_OP_NOSTUFF)
					tx_state_next = TX_STUFF;
				else if (tx_count_reg == 3'h7)
				begin
					if (tx_valid)
					begin
						tx_take       = 1'b1;
						tx_shift_next = tx_data;
						tx_count_next = 3'h0;
					end
					else
						tx_state_next = TX_IDLE;
				end
			end
			TX_STUFF:
			begin
				tx_line_next  = !tx_line;
				tx_ones_next  = 3'h0;
				tx_state_next = TX_SHIFT;
				// A stuff bit after the last data bit still closes the byte.
				if (tx_last_reg)
				begin
					if (tx_valid)
					begin
						tx_take       = 1'b1;
						tx_shift_next = tx_data;
						tx_count_next = 3'h0;
					end
					else
						tx_state_next = TX_IDLE;
				end
			end
			default:
				tx_state_next = TX_IDLE;
		endcase
	end

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			tx_state_reg    <= TX_IDLE;
			tx_shift_reg    <= 8'h00;
			tx_count_reg    <= 3'h0;
			tx_ones_reg     <= 3'h0;
			tx_last_reg     <= 1'b0;
			tx_line         <= 1'b1;
			tx_ready        <= 1'b0;
			hs_tx_drive     <= 1'b0;
			fs_tx_drive     <= 1'b0;
			hs_tx_amplitude <= 3'h0;
		end
		else
		begin
			tx_state_reg    <= tx_state_next;
			tx_shift_reg    <= tx_shift_next;
			tx_count_reg    <= tx_count_next;
			tx_ones_reg     <= tx_ones_next;
			tx_last_reg     <= tx_last_next;
			tx_line         <= tx_line_next;
			tx_ready        <= tx_take;
			// The drive enables follow the next state, so they rise with the move into TX_SHIFT, one clock before the first bit.
			hs_tx_drive     <= (tx_state_next != TX_IDLE) && hs_mode;
			fs_tx_drive     <= (tx_state_next != TX_IDLE) && !hs_mode;
			hs_tx_amplitude <= boost_reg[`UPTD_BOOST_MSB:0];
		end
	end

endmodule // uptd_core

// ==== uptd_defines.vh ====
// Register offsets, field positions, reset values and codes for the termination decode block.
`ifndef UPTD_DEFINES_VH
`define UPTD_DEFINES_VH

`define UPTD_ADDR_FUNC_CTRL   8'h04
`define UPTD_ADDR_OTG_CTRL    8'h0a
`define UPTD_ADDR_TX_BOOST    8'h31
`define UPTD_ADDR_STATUS      8'h40

`define UPTD_FC_XCVR_LSB      0
`define UPTD_FC_XCVR_MSB      1
`define UPTD_FC_TERM_BIT      2
`define UPTD_FC_LINE_OPERATION_SELECT_LSB    3
`define UPTD_FC_LINE_OPERATION_SELECT_MSB    4
`define UPTD_OTG_DP_PD_BIT    1
`define UPTD_OTG_DM_PD_BIT    2
`define UPTD_BOOST_MSB        2

`define UPTD_FC_RESET         8'h01
`define UPTD_OTG_RESET        8'h06
`define UPTD_BOOST_RESET      8'h00

`define UPTD_XCVR_HS          2'h0
`define UPTD_XCVR_FS          2'h1
`define UPTD_XCVR_LS          2'h2
`define UPTD_XCVR_FS4LS       2'h3
`define UPTD_OP_NORMAL        2'h0
`define UPTD_OP_NONDRIVE      2'h1
`define UPTD_OP_NOSTUFF       2'h2

`define UPTD_STUFF_RUN        3'h6

`endif

// ==== uptd_core_asserts.sv ====
// Concurrent checks on the ports of the termination decode block.
module uptd_core_asserts
(
	input wire       clk,
	input wire       sys_rst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire       hs_squelch,
	input wire       se_dplus,
	input wire       se_dminus,
	input wire       rx_bit,
	input wire       rx_bit_valid,
	input wire [1:0] line_state,
	input wire       tx_ready,
	input wire [2:0] hs_tx_amplitude,
	input wire       dplus_pullup_on,
	input wire       dminus_pullup_on,
	input wire       dplus_pulldown_on,
	input wire       dminus_pulldown_on,
	input wire       fast_termination_on
);
	timeunit 1ns;
	timeprecision 1ps;
	wire [4:0] term = {dplus_pullup_on, dminus_pullup_on, dplus_pulldown_on,
		dminus_pulldown_on, fast_termination_on};
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_nondrive_off: assert property (reg_wr && reg_addr == 8'h04 && reg_wdata[4:3] == 2'h1
		|-> ##2 term == 5'h00) else $error("Enables on in tri-state mode.");
	a_hsterm_alone: assert property (fast_termination_on
		|-> !dplus_pullup_on && !dminus_pullup_on) else $error("Pull-up beside termination.");
	a_dm_pullup_only: assert property (dminus_pullup_on |-> term == 5'h08)
		else $error("DM pull-up not alone.");
	a_line_follow: assert property ($past(!sys_rst)
		|-> line_state == {$past(se_dminus), $past(se_dplus)}) else $error("Line state lag.");
	a_squelch_gate: assert property ($past(!sys_rst) && !rx_bit_valid
		|-> !rx_bit && $past(hs_squelch)) else $error("Receive gate without squelch.");
	a_amp_follow: assert property (reg_wr && reg_addr == 8'h31
		|-> ##2 hs_tx_amplitude == $past(reg_wdata[2:0], 2)) else $error("Trim not applied.");
	a_byte_spacing: assert property (tx_ready |=> !tx_ready [*7])
		else $error("Bytes taken too fast.");
	a_status_read: assert property (reg_rd && reg_addr == 8'h40
		|=> reg_rdata == {1'b0, $past(line_state), $past(term)}) else $error("Status mismatch.");
endmodule // uptd_core_asserts

bind uptd_core uptd_core_asserts u_uptd_core_asserts (.*);

// ==== uptd_link.sv ====
// Link controller model driving the register port of the transceiver logic.
module uptd_link
(
	input  wire        clk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic       reg_wr,
	output logic       reg_rd,
	input  wire  [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Any setting is written as given, unlisted rows included; a hub-port setup has no encoding here.
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stands for one cycle only, so it is taken mid-cycle after the strobe.
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask
endmodule // uptd_link

// ==== uptd_core_tb.sv ====
// Self-checking testbench for the termination decode block.
module uptd_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0, sys_rst = 1'b1, tx_valid = 1'b0;
	logic       hs_rx_bit = 1'b0, fs_rx_bit = 1'b0, hs_squelch = 1'b1;
	logic       se_dplus = 1'b0, se_dminus = 1'b0;
	logic [7:0] tx_data = 8'h00;
	int         failures = 0, comparisons = 0, cycles = 0;
	wire  [7:0] reg_addr, reg_wdata, reg_rdata;
	wire        reg_wr, reg_rd, rx_bit, rx_bit_valid, tx_ready, tx_line, hs_tx_drive, fs_tx_drive;
	wire  [1:0] line_state;
	wire  [2:0] hs_tx_amplitude;
	wire        dplus_pullup_on, dminus_pullup_on, dplus_pulldown_on;
	wire        dminus_pulldown_on, fast_termination_on;
	wire  [4:0] term = {dplus_pullup_on, dminus_pullup_on, dplus_pulldown_on,
		dminus_pulldown_on, fast_termination_on};
	// Rows: xcvr, term select, line op, DP and DM pull-down requests, expected enables.
	localparam logic [11:0] DEC [18] = '{12'b01_0_00_11_00110, 12'b00_0_01_11_00000,
		12'b00_0_10_11_00111, 12'b00_0_00_11_00111, 12'b11_1_00_11_00110,
		12'b01_1_10_11_00110, 12'b10_1_10_11_00110, 12'b00_1_10_00_10000,
		12'b00_0_00_00_00001, 12'b01_1_00_00_10000, 12'b10_1_00_00_01000,
		12'b00_1_10_01_10010, 12'b00_0_00_01_00011, 12'b11_0_00_00_00000,
		12'b01_1_01_00_00000, 12'b00_0_11_00_00000, 12'b01_1_11_11_00000,
		12'b01_1_00_10_00000};
	uptd_core u_uptd_core (.*);
	uptd_link u_uptd_link (.*);
	always #20 clk = ~clk;
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 4000)
		begin
			failures++;
			close_out();
		end
	end
	task close_out;
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task set_mode(input logic [11:0] m);
		u_uptd_link.wr(8'h04, {3'h0, m[8:7], m[9], m[11:10]});
		u_uptd_link.wr(8'h0a, {5'h0, m[5], m[6], 1'b0});
		repeat (2) @(negedge clk);
	endtask
	task t_reset;
		logic [7:0] d;
		@(posedge clk);
		@(negedge clk);
		cmp({3'h0, term}, 8'h06);
		u_uptd_link.rd(8'h04, d);
		cmp(d, 8'h01);
		u_uptd_link.rd(8'h0a, d);
		cmp(d, 8'h06);
		u_uptd_link.rd(8'h31, d);
		cmp(d, 8'h00);
		u_uptd_link.rd(8'h77, d);
		cmp(d, 8'h00);
	endtask
	task t_decode;
		for (int i = 0; i < 18; i++)
		begin
			set_mode(DEC[i]);
			cmp({3'h0, term}, {3'h0, DEC[i][4:0]});
		end
	endtask
	task t_rx;
		logic [7:0] d;
		set_mode(12'b00_0_00_00_00001);
		@(posedge clk) hs_rx_bit <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		cmp({6'h0, rx_bit_valid, rx_bit}, 8'h00);
		@(posedge clk) hs_squelch <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		cmp({6'h0, rx_bit_valid, rx_bit}, 8'h03);
		set_mode(12'b01_1_00_00_10000);
		@(posedge clk) se_dplus <= 1'b1;
		fs_rx_bit <= 1'b1;
		hs_rx_bit <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		cmp({6'h0, rx_bit_valid, rx_bit}, 8'h03);
		cmp({6'h0, line_state}, 8'h01);
		u_uptd_link.rd(8'h40, d);
		cmp(d, 8'h30);
	endtask
	task t_tx(input logic [11:0] m, input logic [7:0] b, input int n, input logic [7:0] e);
		logic [7:0] tog;
		logic       prev;
		int         i;
		tog = 8'h00;
		set_mode(m);
		u_uptd_link.wr(8'h31, 8'h05);
		@(posedge clk);
		tx_data <= b;
		tx_valid <= 1'b1;
		for (i = 0; i < 20 && tx_ready !== 1'b1; i++)
			@(negedge clk);
		cmp({5'h0, hs_tx_amplitude}, 8'h05);
		cmp({6'h0, hs_tx_drive, fs_tx_drive}, {6'h0, m[11:10] == 2'h0, m[11:10] != 2'h0});
		prev = tx_line;
		@(posedge clk) tx_valid <= 1'b0;
		for (i = 0; i < n; i++)
		begin
			@(negedge clk);
			tog[i] = tx_line ^ prev;
			prev = tx_line;
		end
		cmp(tog, e);
		repeat (6) @(negedge clk);
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_decode();
		t_rx();
		t_tx(12'b00_0_00_00_00001, 8'h00, 8, 8'hff);
		t_tx(12'b01_1_00_00_10000, 8'hff, 7, 8'h40);
		close_out();
	end
endmodule // uptd_core_tb
